// ==== csr_swap_pkg.sv ====
// Package with register map, field layout and constants of the compare-swap block.
package csr_swap_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_NEW_VALUE = 8'h0c;
    localparam logic [7:0] OFS_EXPECTED = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_ROM_HEADER = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_LINK_CTRL = 8'h2c;
    localparam int unsigned DONE_BIT = 31;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned LINK_ON_BIT = 17;
    localparam int unsigned CHECK_W = 16;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int unsigned NUM_RES = 4;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_LOAD = 1;
    // Reset values of the four bus-management resources; arbitrary defaults.
    localparam logic [31:0] RES_INIT [NUM_RES] = '{32'h0000_003f,
        32'h0000_1333, 32'hffff_ffff, 32'hffff_ffff};
    typedef enum logic [1:0] {SEL_BUS_MANAGER, SEL_BANDWIDTH,
                              SEL_CHANNELS_HI, SEL_CHANNELS_LO} resource_t;
    typedef enum logic [1:0] {SW_IDLE, SW_READ, SW_DONE} swap_state_t;
endpackage

// ==== csr_resource_file.sv ====
// Storage for the four bus-management resources with an atomic compare-swap.
`timescale 1ns/100ps
module csr_resource_file
    import csr_swap_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               start_i,
    input  wire csr_swap_pkg::resource_t sel_i,
    input  wire logic [31:0]        new_value_i,
    input  wire logic [31:0]        expected_i,
    output logic                    done_o,
    output logic [31:0]             prior_o
);
    import csr_swap_pkg::*;

    logic [31:0] res_q [NUM_RES];

    genvar g;
    generate
        for (g = 0; g < NUM_RES; g++)
        begin : g_res
            always_ff @(posedge sys_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    res_q[g] <= RES_INIT[g];
                else if (start_i && (sel_i == resource_t'(g))
                         && (res_q[g] == expected_i))
                    res_q[g] <= new_value_i;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            done_o  <= 1'b0;
            prior_o <= RESET_WORD;
        end
        else
        begin
            done_o <= start_i;
            if (start_i)
                prior_o <= res_q[sel_i];
        end
    end
endmodule

// ==== rom_check_loader.sv ====
// Reads the header check value from a serial EEPROM once after reset.
`timescale 1ns/100ps
module rom_check_loader
    import csr_swap_pkg::*;
#(
    parameter int unsigned DIV = 10
)
(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               present_i,
    input  wire logic               sda_i,
    output logic                    scl_o,
    output logic                    load_o,
    output logic [CHECK_W-1:0]      value_o
);
    import csr_swap_pkg::*;

    if (DIV < 2)
    begin : g_bad_div
        $error("DIV must be at least 2");
    end

    logic [15:0] div_q;
    logic [4:0]  bit_q;
    logic        busy_q;
    logic [2:0]  sda_sync_q;
    logic [2:0]  present_sync_q;
    logic        tick;

    assign tick = (div_q == 16'(DIV - 1));

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sda_sync_q     <= 3'h0;
            present_sync_q <= 3'h7;
        end
        else
        begin
            sda_sync_q     <= {sda_sync_q[1:0], sda_i};
            present_sync_q <= {present_sync_q[1:0], present_i};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            div_q <= 16'h0000;
        else if (tick)
            div_q <= 16'h0000;
        else
            div_q <= div_q + 16'h0001;
    end

    // Sixteen clock pulses; each bit is taken at the end of the high half,
    // so the synchroniser already holds pin data and not its reset value.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_q  <= 1'b1;
            bit_q   <= 5'h00;
            scl_o   <= 1'b0;
            load_o  <= 1'b0;
            value_o <= 16'h0000;
        end
        else
        begin
            load_o <= 1'b0;
            if (busy_q && !present_sync_q[2] && !present_sync_q[1])
            begin
                busy_q <= 1'b0;
                scl_o  <= 1'b0;
            end
            else if (busy_q && tick)
            begin
                scl_o <= ~scl_o;
                if (scl_o && (sda_sync_q[2] == sda_sync_q[1]))
                begin
                    value_o <= {value_o[CHECK_W-2:0], sda_sync_q[2]};
                    bit_q   <= bit_q + 5'h01;
                    if (bit_q == 5'(CHECK_W - 1))
                    begin
                        busy_q <= 1'b0;
                        load_o <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ==== swap_expected_value_swap_regs.sv ====
// AHB-Lite register bank for compare-swap access and the ROM header quadlet.
//
// Notes on behaviour
// - Data register at 0Ch gives the value written on a compare match.
// - Compare register at 10h holds the value checked against the resource.
// - Bit 31 of control at 14h sets when a compare-swap finishes.
// - A control write clears the completion bit regardless of bit 31, unless a swap finishes in that cycle.
// - Bits 1-0 of control pick one of four resources, read/write.
// - Control bits 30-2 always read as zero.
// - Header register at 18h is the first configuration ROM quadlet.
// - With an EEPROM fitted, the check value preloads after reset.
// - Without EEPROM, check value stays zero; upper half resets zero.
`timescale 1ns/100ps
module swap_expected_value_swap_regs
    import csr_swap_pkg::*;
#(
    parameter int unsigned EEPROM_DIV = 10
)
(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic [31:0]             hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    input  wire logic               eeprom_present_i,
    input  wire logic               eeprom_sda_i,
    output logic                    eeprom_scl_o,
    output logic [31:0]             rom_header_o,
    output logic                    link_on_o,
    output logic                    irq_o
);
    import csr_swap_pkg::*;

    logic [31:0]        new_value_q;
    logic [31:0]        expected_q;
    logic               done_q;
    resource_t          sel_q;
    logic [31:0]        header_q;
    logic [IRQ_W-1:0]   irq_status_q;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic               wr_pend_q;
    logic               rd_pend_q;
    logic [ADDR_W-1:0]  addr_q;
    logic               start_q;
    logic               swap_done;
    logic [31:0]        prior;
    logic               rom_load;
    logic [CHECK_W-1:0] rom_value;
    logic               eeprom_scl;
    logic               wr_ctrl;
    logic               rd_status;
    logic [31:0]        rd_word;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    csr_resource_file u_res (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .start_i     (start_q),
        .sel_i       (sel_q),
        .new_value_i (new_value_q),
        .expected_i  (expected_q),
        .done_o      (swap_done),
        .prior_o     (prior)
    );

    rom_check_loader #(.DIV(EEPROM_DIV)) u_rom (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .present_i (eeprom_present_i),
        .sda_i     (eeprom_sda_i),
        .scl_o     (eeprom_scl),
        .load_o    (rom_load),
        .value_o   (rom_value)
    );

    // Address phase is captured; a write data phase completes in one cycle.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end
        else if (hready_i)
        begin
            wr_pend_q <= hsel_i && (htrans_i == HTRANS_NONSEQ) && hwrite_i;
            rd_pend_q <= hsel_i && (htrans_i == HTRANS_NONSEQ) && !hwrite_i;
            addr_q    <= haddr_i[ADDR_W-1:0];
        end
    end

    assign wr_ctrl   = wr_pend_q && hit(addr_q, OFS_CONTROL);
    assign rd_status = rd_pend_q && hit(addr_q, OFS_IRQ_STATUS);

    // Data and compare are written from the bus; a finished swap loads data with the prior value.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            new_value_q <= RESET_WORD;
            expected_q  <= RESET_WORD;
        end
        else if (swap_done)
            new_value_q <= prior;
        else if (wr_pend_q && hit(addr_q, OFS_NEW_VALUE))
            new_value_q <= hwdata_i;
        else if (wr_pend_q && hit(addr_q, OFS_EXPECTED))
            expected_q <= hwdata_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sel_q   <= SEL_BUS_MANAGER;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= wr_ctrl;
            if (wr_ctrl)
                sel_q <= resource_t'(hwdata_i[SEL_W-1:0]);
        end
    end

    // Completion sets over a simultaneous clearing write.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            done_q <= 1'b0;
        else if (swap_done)
            done_q <= 1'b1;
        else if (wr_ctrl)
            done_q <= 1'b0;
    end

    // Upper half resets to zero; the check half holds zero until loaded.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            header_q <= RESET_WORD;
        else if (rom_load)
            header_q[CHECK_W-1:0] <= rom_value;
        else if (wr_pend_q && hit(addr_q, OFS_ROM_HEADER))
            header_q <= hwdata_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            link_on_o  <= 1'b0;
            irq_mask_q <= '0;
        end
        else if (wr_pend_q && hit(addr_q, OFS_LINK_CTRL))
            link_on_o <= hwdata_i[LINK_ON_BIT];
        else if (wr_pend_q && hit(addr_q, OFS_IRQ_MASK))
            irq_mask_q <= hwdata_i[IRQ_W-1:0];
    end

    // A status read clears the sticky bits, but a new event wins.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_status_q <= '0;
        else
        begin
            irq_status_q[IRQ_DONE] <= swap_done
                || (irq_status_q[IRQ_DONE] && !rd_status);
            irq_status_q[IRQ_LOAD] <= rom_load
                || (irq_status_q[IRQ_LOAD] && !rd_status);
        end
    end

    always_comb
    begin
        rd_word = RESET_WORD;
        if (hit(addr_q, OFS_NEW_VALUE))
            rd_word = new_value_q;
        else if (hit(addr_q, OFS_EXPECTED))
            rd_word = expected_q;
        else if (hit(addr_q, OFS_CONTROL))
        begin
            rd_word[DONE_BIT]      = done_q;
            rd_word[SEL_W-1:0]     = sel_q;
        end
        else if (hit(addr_q, OFS_ROM_HEADER))
            rd_word = header_q;
        else if (hit(addr_q, OFS_IRQ_STATUS))
            rd_word[IRQ_W-1:0] = irq_status_q;
        else if (hit(addr_q, OFS_IRQ_MASK))
            rd_word[IRQ_W-1:0] = irq_mask_q;
        else if (hit(addr_q, OFS_LINK_CTRL))
            rd_word[LINK_ON_BIT] = link_on_o;
    end

    // Read data is registered, so a read takes one wait state.
    logic rd_wait_q;
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_wait_q   <= 1'b0;
            hreadyout_o <= 1'b1;
            hrdata_o    <= RESET_WORD;
        end
        else
        begin
            rd_wait_q   <= hready_i && hsel_i && !hwrite_i
                           && (htrans_i == HTRANS_NONSEQ);
            hreadyout_o <= !(hready_i && hsel_i && !hwrite_i
                           && (htrans_i == HTRANS_NONSEQ));
            if (rd_wait_q)
                hrdata_o <= rd_word;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hresp_o      <= 1'b0;
            irq_o        <= 1'b0;
            eeprom_scl_o <= 1'b0;
            rom_header_o <= RESET_WORD;
        end
        else
        begin
            hresp_o      <= 1'b0;
            irq_o        <= |(irq_status_q & irq_mask_q);
            eeprom_scl_o <= eeprom_scl;
            rom_header_o <= header_q;
        end
    end
endmodule

// ==== csr_swap_props.sv ====
// Port-level properties of the compare-swap register bank.
`timescale 1ns/100ps
module csr_swap_props
    import csr_swap_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o,
    input  wire logic [31:0] rom_header_o
);
    logic        ap;
    logic        rv;
    logic        wd;
    logic [7:0]  ra;
    logic        wv_q;
    logic [7:0]  wa_q;
    logic [31:0] exp_q;
    logic [31:0] new_q;
    logic        fresh_q;
    logic [1:0]  sel_q;
    logic        seen_q;
    logic        hw_q;
    logic [3:0]  age_q;
    assign ap = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    assign rv = ap && !hwrite_i;
    assign ra = haddr_i[7:0];
    assign wd = wv_q && hready_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Shadow of what the host wrote; age counts cycles since a control write.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wv_q <= 1'b0;
            wa_q <= 8'h00;
            exp_q <= 32'h0000_0000;
            new_q <= 32'h0000_0000;
            fresh_q <= 1'b0;
            sel_q <= 2'h0;
            seen_q <= 1'b0;
            hw_q <= 1'b0;
            age_q <= 4'hf;
        end
        else
        begin
            wv_q <= ap && hwrite_i;
            wa_q <= ra;
            age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
            if (wd && wa_q == OFS_EXPECTED)
                exp_q <= hwdata_i;
            if (wd && wa_q == OFS_NEW_VALUE && age_q > 4'h2)
            begin
                new_q <= hwdata_i;
                fresh_q <= 1'b1;
            end
            if (wd && wa_q == OFS_CONTROL)
            begin
                sel_q <= hwdata_i[1:0];
                seen_q <= 1'b1;
                fresh_q <= 1'b0;
                age_q <= 4'h0;
            end
            if (wd && wa_q == OFS_ROM_HEADER)
                hw_q <= 1'b1;
        end
    end
    property hdr_copy_p;
        logic [31:0] d;
        (ap && hwrite_i && ra == OFS_ROM_HEADER) ##1 (1'b1, d = hwdata_i)
            |-> ##[1:2] rom_header_o == d;
    endproperty
    read_wait_a: assert property (rv |=> !hreadyout_o ##1 hreadyout_o)
        else $error("Read data phase wait state is wrong.");
    new_value_a: assert property (rv && ra == OFS_NEW_VALUE && fresh_q
        && age_q > 4'h3 |-> ##2 hrdata_o == new_q)
        else $error("Data register does not return the written value.");
    compare_keep_a: assert property (rv && ra == OFS_EXPECTED
        |-> ##2 hrdata_o == exp_q)
        else $error("Compare register does not hold the written value.");
    done_flag_a: assert property (rv && ra == OFS_CONTROL
        && age_q != 4'h0 && !(wd && wa_q == OFS_CONTROL)
        |-> ##2 hrdata_o[31] == seen_q)
        else $error("Completion flag wrong after a swap.");
    ctrl_sel_a: assert property (rv && ra == OFS_CONTROL
        |-> ##2 hrdata_o[1:0] == sel_q)
        else $error("Resource select does not read back.");
    ctrl_rsvd_a: assert property (rv && ra == OFS_CONTROL
        |-> ##2 hrdata_o[30:2] == 29'h0)
        else $error("Reserved control bits are not zero.");
    hdr_copy_a: assert property (hdr_copy_p)
        else $error("Header output does not follow the header register.");
    hdr_upper_a: assert property (!hw_q |-> rom_header_o[31:16] == 16'h0)
        else $error("Header upper half not zero after reset.");
    cover property (wd && wa_q == OFS_CONTROL);
    cover property (rv && ra == OFS_CONTROL && seen_q && age_q != 4'h0);
    cover property (wd && wa_q == OFS_ROM_HEADER);
endmodule

bind swap_expected_value_swap_regs csr_swap_props props_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .rom_header_o(rom_header_o));

// ==== tb_swap_expected_value_swap_regs.sv ====
// Self-checking testbench of the compare-swap register bank.
`timescale 1ns/100ps
module tb_swap_expected_value_swap_regs;
    import csr_swap_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        scl;
    logic [31:0] hdr;
    logic        link_on;
    logic        irq;
    logic [31:0] v;
    logic        eeprom_present = 1'b1;
    logic        sda;
    logic        scl_d = 1'b0;
    logic [15:0] rom_bits = 16'ha5c3;
    int          miscompares = 0;
    int          total_checks = 0;

    always #25 clk = ~clk;

    // Serial EEPROM stand-in: the next bit goes out after each falling clock.
    assign sda = rom_bits[15];
    always @(posedge clk)
    begin
        scl_d <= scl;
        if (scl_d && !scl)
            rom_bits <= {rom_bits[14:0], 1'b1};
    end

    swap_expected_value_swap_regs #(.EEPROM_DIV(8)) uut (
        .sys_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp),
        .eeprom_present_i(eeprom_present), .eeprom_sda_i(sda),
        .eeprom_scl_o(scl),
        .rom_header_o(hdr), .link_on_o(link_on), .irq_o(irq));

    task automatic results;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
        xfer(a, 1'b0, 32'h0);
        chk(n, v, e);
    endtask

    // Loads both operands, starts a swap and polls until it completes.
    task automatic swap(input logic [1:0] s, input logic [31:0] nv, cmp);
        wr(OFS_NEW_VALUE, nv);
        wr(OFS_EXPECTED, cmp);
        wr(OFS_CONTROL, 32'hffff_fffc | {30'h0, s});
        do xfer(OFS_CONTROL, 1'b0, 32'h0); while (v[31] !== 1'b1);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rc(OFS_NEW_VALUE, 32'h0, "data reset");
        rc(OFS_EXPECTED, 32'h0, "compare reset");
        rc(OFS_CONTROL, 32'h0, "control reset");
        do xfer(OFS_IRQ_STATUS, 1'b0, 32'h0); while (v[1] !== 1'b1);
        rc(OFS_ROM_HEADER, 32'h0000_a5c3, "header preload");
        wr(OFS_NEW_VALUE, 32'h1234_5678);
        rc(OFS_NEW_VALUE, 32'h1234_5678, "data write");
        for (int s = 0; s < 4; s++)
        begin
            swap(s[1:0], 32'h0000_0a00 + 32'(s), RES_INIT[s]);
            chk("control", v, {1'b1, 29'h0, s[1:0]});
            rc(OFS_NEW_VALUE, RES_INIT[s], "prior on match");
            // A store on a miss would show the dead value on the second pass.
            repeat (2)
            begin
                swap(s[1:0], 32'hdead_0000, 32'h0);
                rc(OFS_EXPECTED, 32'h0, "compare kept");
                rc(OFS_NEW_VALUE, 32'h0000_0a00 + 32'(s), "prior miss");
            end
        end
        rc(OFS_IRQ_STATUS, 32'h1, "sticky status");
        wr(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq after clear", {31'h0, irq}, 32'h0);
        swap(2'h0, 32'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        rc(OFS_IRQ_STATUS, 32'h1, "status");
        repeat (2) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        swap(2'h1, 32'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rc(OFS_IRQ_STATUS, 32'h1, "masked status");
        wr(OFS_ROM_HEADER, 32'h0420_abcd);
        rc(OFS_ROM_HEADER, 32'h0420_abcd, "header rw");
        chk("header out", hdr, 32'h0420_abcd);
        wr(OFS_LINK_CTRL, 32'h0002_0000);
        repeat (2) @(posedge clk);
        chk("link on", {31'h0, link_on}, 32'h1);
        wr(8'h30, 32'hffff_ffff);
        rc(8'h30, 32'h0, "unmapped");
        chk("response", {31'h0, hresp}, 32'h0);
        // Second reset with no EEPROM fitted: nothing may be loaded.
        eeprom_present <= 1'b0;
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (300) @(posedge clk);
        rc(OFS_IRQ_STATUS, 32'h0, "no preload");
        xfer(OFS_ROM_HEADER, 1'b0, 32'h0);
        chk("header upper", {v[31:16], 16'h0}, 32'h0);
        results;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results;
    end
endmodule
